// ==== dbcam_top.sv ====
// Bank and low column address mapper with its configuration registers.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`default_nettype none

// Overview of operation
// - Bank bit 0 comes from address bit two plus bank0 selector, range 0..14.
// - Bank bit 1 comes from address bit three plus bank1 selector, range 0..14.
// - Bank bit 2 comes from address bit four plus selector; fifteen forces zero.
// - Column B2 selector, base 2, drives column bit 3, 4 or 5 by width.
// - Column B3 selector, base 3, drives column bit 4, 5 or 6 by width.
// - Column B4 selector, base 4, drives column bit 5, 6 or 7 by width.
// - Column B7 selector, base 7, drives column bit 8, 9 or 11 by width.
// - Column B7 selector at fifteen forces its column bit to zero.
// - Column bit 10 is never taken from the address; it stays zero.
// - Width mode: 00 full, 01 half, 10 quarter, 11 reserved.
module dbcam_top (
  // Clock and reset.
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  // Register port.
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [31:0] O_REG_RDATA,
  // Incoming transaction address.
  input  wire logic        I_TXN_VALID,
  input  wire logic [31:0] I_TXN_ADDR,
  // Mapped bank and column towards the scheduler.
  output logic             O_MAP_VALID,
  output logic      [2:0]  O_MAP_BANK,
  output logic      [11:0] O_MAP_COL
);

  // Picks one address bit at base plus selector; returns zero past the top.
  function automatic logic pick_bit(input logic [31:0] addr, input logic [4:0] base,
                                    input logic [3:0] sel);
    logic [5:0] idx;
    idx = 6'({1'b0, base} + {2'b00, sel});
    pick_bit = (idx < 6'd32) ? addr[idx[4:0]] : 1'b0;
  endfunction : pick_bit

  // Configuration and state registers.
  logic [11:0] bank_sel_ff;
  logic [15:0] col_low_ff;
  logic [15:0] col_high_ff;
  logic [1:0]  mode_ff;
  logic        unsup_ff;
  logic [31:0] rdata_ff;
  logic        map_valid_ff;
  logic [2:0]  map_bank_ff;
  logic [11:0] map_col_ff;

  // Field views of the selector registers.
  wire logic [3:0] bank0_sel = bank_sel_ff[dbcam_pkg::BANK0_LSB +: 4];
  wire logic [3:0] bank1_sel = bank_sel_ff[dbcam_pkg::BANK1_LSB +: 4];
  wire logic [3:0] bank2_sel = bank_sel_ff[dbcam_pkg::BANK2_LSB +: 4];
  wire logic [3:0] col_b2_sel = col_low_ff[dbcam_pkg::COL_B2_LSB +: 4];
  wire logic [3:0] col_b3_sel = col_low_ff[dbcam_pkg::COL_B3_LSB +: 4];
  wire logic [3:0] col_b4_sel = col_low_ff[dbcam_pkg::COL_B4_LSB +: 4];
  wire logic [3:0] col_b7_sel = col_low_ff[dbcam_pkg::COL_B7_LSB +: 4];
  wire dbcam_pkg::dbcam_width_t dq_width_mode = dbcam_pkg::dbcam_width_t'(mode_ff);

  // Register address decode.
  wire logic hit_bank   = (I_REG_ADDR == dbcam_pkg::OFS_BANK_SEL);
  wire logic hit_col_lo = (I_REG_ADDR == dbcam_pkg::OFS_COL_LOW_SEL);
  wire logic hit_col_hi = (I_REG_ADDR == dbcam_pkg::OFS_COL_HIGH_SEL);
  wire logic hit_mode   = (I_REG_ADDR == dbcam_pkg::OFS_MODE);
  wire logic hit_status = (I_REG_ADDR == dbcam_pkg::OFS_STATUS);

  // Bank bits; an out-of-range selector yields zero rather than a wrong source.
  wire logic bank0_bit = (bank0_sel <= dbcam_pkg::BANK_SEL_MAX) &&
                         pick_bit(I_TXN_ADDR, dbcam_pkg::BANK0_BASE, bank0_sel);
  wire logic bank1_bit = (bank1_sel <= dbcam_pkg::BANK_SEL_MAX) &&
                         pick_bit(I_TXN_ADDR, dbcam_pkg::BANK1_BASE, bank1_sel);
  wire logic bank2_bit = (bank2_sel != dbcam_pkg::SEL_OFF) &&
                         pick_bit(I_TXN_ADDR, dbcam_pkg::BANK2_BASE, bank2_sel);

  // Column source bits before they are placed by the width mode.
  wire logic b2_ok = (col_b2_sel <= dbcam_pkg::COL_SEL_MAX);
  wire logic b3_ok = (col_b3_sel <= dbcam_pkg::COL_SEL_MAX);
  wire logic b4_ok = (col_b4_sel <= dbcam_pkg::COL_SEL_MAX);
  wire logic b7_ok = (col_b7_sel <= dbcam_pkg::COL_SEL_MAX);
  wire logic b2_bit = b2_ok && pick_bit(I_TXN_ADDR, dbcam_pkg::COL_B2_BASE, col_b2_sel);
  wire logic b3_bit = b3_ok && pick_bit(I_TXN_ADDR, dbcam_pkg::COL_B3_BASE, col_b3_sel);
  wire logic b4_bit = b4_ok && pick_bit(I_TXN_ADDR, dbcam_pkg::COL_B4_BASE, col_b4_sel);
  // Fifteen and anything above seven leave this bit at zero.
  wire logic b7_bit = b7_ok && pick_bit(I_TXN_ADDR, dbcam_pkg::COL_B7_BASE, col_b7_sel);

  // Selectors outside their legal range, and the reserved width mode.
  wire logic unsup_now = (bank0_sel > dbcam_pkg::BANK_SEL_MAX) ||
                         (bank1_sel > dbcam_pkg::BANK_SEL_MAX) ||
                         !b2_ok || !b3_ok || !b4_ok ||
                         (!b7_ok && col_b7_sel != dbcam_pkg::SEL_OFF) ||
                         (dq_width_mode == dbcam_pkg::DBCAM_RSVD);

  // Column placement by width mode; bit 10 is never written here.
  logic [11:0] col_map;
  always_comb begin
    col_map = 12'h000;
    case (dq_width_mode)
      dbcam_pkg::DBCAM_FULL: begin
        col_map[3] = b2_bit;
        col_map[4] = b3_bit;
        col_map[5] = b4_bit;
        col_map[8] = b7_bit;
      end
      dbcam_pkg::DBCAM_HALF: begin
        col_map[4] = b2_bit;
        col_map[5] = b3_bit;
        col_map[6] = b4_bit;
        col_map[9] = b7_bit;
      end
      dbcam_pkg::DBCAM_QUARTER: begin
        col_map[5]  = b2_bit;
        col_map[6]  = b3_bit;
        col_map[7]  = b4_bit;
        col_map[11] = b7_bit;
      end
      default: begin
        // Reserved width mode drives no column bits at all.
        col_map = 12'h000;
      end
    endcase
  end

  // Next values of the status flag; a new event wins over a clear in the same cycle.
  wire logic unsup_clr = I_REG_WR && hit_status && I_REG_WDATA[dbcam_pkg::STAT_UNSUP_LSB];
  wire logic unsup_set = I_TXN_VALID && unsup_now;
  wire logic nxt_unsup = unsup_set || (unsup_ff && !unsup_clr);

  // Read data mux; reserved bits and unmapped offsets read as zero.
  wire logic [31:0] nxt_rdata =
      !I_REG_RD  ? 32'h0000_0000 :
      hit_bank   ? {20'h00000, bank_sel_ff} :
      hit_col_lo ? {16'h0000, col_low_ff} :
      hit_col_hi ? {16'h0000, col_high_ff} :
      hit_mode   ? {30'h0000_0000, mode_ff} :
      hit_status ? {12'h000, map_col_ff, 1'b0, map_bank_ff, 3'h0, unsup_ff} :
                   32'h0000_0000;

  // Configuration registers; only the defined fields are stored.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      bank_sel_ff <= dbcam_pkg::BANK_SEL_RST;
      col_low_ff  <= dbcam_pkg::COL_SEL_RST;
      col_high_ff <= dbcam_pkg::COL_SEL_RST;
      mode_ff     <= dbcam_pkg::MODE_RST;
    end else if (I_REG_WR) begin
      if (hit_bank)   bank_sel_ff <= I_REG_WDATA[11:0];
      if (hit_col_lo) col_low_ff  <= I_REG_WDATA[15:0];
      if (hit_col_hi) col_high_ff <= I_REG_WDATA[15:0];
      if (hit_mode)   mode_ff     <= I_REG_WDATA[1:0];
    end
  end

  // Status flag and read data register.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      unsup_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      unsup_ff <= nxt_unsup;
      rdata_ff <= nxt_rdata;
    end
  end

  // Mapping stage: one register so the scheduler sees a clean, aligned result.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      map_valid_ff <= 1'b0;
      map_bank_ff  <= 3'h0;
      map_col_ff   <= 12'h000;
    end else begin
      map_valid_ff <= I_TXN_VALID;
      if (I_TXN_VALID) begin
        map_bank_ff <= {bank2_bit, bank1_bit, bank0_bit};
        map_col_ff  <= col_map;
      end
    end
  end

  assign O_REG_RDATA = rdata_ff;
  assign O_MAP_VALID = map_valid_ff;
  assign O_MAP_BANK  = map_bank_ff;
  assign O_MAP_COL   = map_col_ff;

  // Checks of the mapping relations, sampled one cycle after the address arrives.
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  bank0_source_a: assert property (
    I_TXN_VALID && bank0_sel <= 4'hE |=>
      O_MAP_BANK[0] == $past(I_TXN_ADDR[5'd2 + {1'b0, bank0_sel}]))
    else $error("Bank bit 0 not taken from its selected address bit.");

  bank1_source_a: assert property (
    I_TXN_VALID && bank1_sel <= 4'hE |=>
      O_MAP_BANK[1] == $past(I_TXN_ADDR[5'd3 + {1'b0, bank1_sel}]))
    else $error("Bank bit 1 not taken from its selected address bit.");

  bank2_map_a: assert property (
    I_TXN_VALID |=> O_MAP_BANK[2] ==
      ($past(bank2_sel) == 4'hF ? 1'b0 : $past(I_TXN_ADDR[5'd4 + {1'b0, bank2_sel}])))
    else $error("Bank bit 2 wrong for its selector.");

  col_b2_full_a: assert property (
    I_TXN_VALID && mode_ff == 2'b00 && col_b2_sel <= 4'h7 |=>
      O_MAP_COL[3] == $past(I_TXN_ADDR[5'd2 + {1'b0, col_b2_sel}]))
    else $error("Full width column bit 3 wrong.");

  col_b3_half_a: assert property (
    I_TXN_VALID && mode_ff == 2'b01 && col_b3_sel <= 4'h7 |=>
      O_MAP_COL[5] == $past(I_TXN_ADDR[5'd3 + {1'b0, col_b3_sel}]))
    else $error("Half width column bit 5 wrong.");

  col_b4_quarter_a: assert property (
    I_TXN_VALID && mode_ff == 2'b10 && col_b4_sel <= 4'h7 |=>
      O_MAP_COL[7] == $past(I_TXN_ADDR[5'd4 + {1'b0, col_b4_sel}]))
    else $error("Quarter width column bit 7 wrong.");

  col_b7_quarter_a: assert property (
    I_TXN_VALID && mode_ff == 2'b10 && col_b7_sel <= 4'h7 |=>
      O_MAP_COL[11] == $past(I_TXN_ADDR[5'd7 + {1'b0, col_b7_sel}]) && !O_MAP_COL[8])
    else $error("Quarter width column bit 11 wrong.");

  col_b7_off_a: assert property (
    I_TXN_VALID && col_b7_sel == 4'hF |=> !O_MAP_COL[8] && !O_MAP_COL[9] && !O_MAP_COL[11])
    else $error("Column B7 bit not forced to zero.");

  col_bit10_a: assert property (
    O_MAP_COL[10] == 1'b0)
    else $error("Column bit 10 sourced from the address.");

  mode_reserved_a: assert property (
    I_TXN_VALID && mode_ff == 2'b11 |=> O_MAP_COL == 12'h000 && unsup_ff)
    else $error("Reserved width mode produced column bits.");

  unsup_flag_a: assert property (
    I_TXN_VALID && bank0_sel == 4'hF |=> unsup_ff [*2])
    else $error("Unsupported selector not flagged or not held.");

  map_latency_a: assert property (
    I_TXN_VALID |=> O_MAP_VALID ##1 (O_MAP_VALID == $past(I_TXN_VALID)))
    else $error("Mapped result not one cycle after the address.");

  // Remaining placements of each column field, so every mode and field is watched.
  col_b2_half_a: assert property (
    I_TXN_VALID && mode_ff == 2'h1 && col_b2_sel <= 4'h7 |=>
      O_MAP_COL[4] == $past(I_TXN_ADDR[5'h02 + {1'b0, col_b2_sel}]))
    else $error("Half width column bit 4 wrong.");

  col_b2_quarter_a: assert property (
    I_TXN_VALID && mode_ff == 2'h2 && col_b2_sel <= 4'h7 |=>
      O_MAP_COL[5] == $past(I_TXN_ADDR[5'h02 + {1'b0, col_b2_sel}]))
    else $error("Quarter width column bit 5 wrong.");

  col_b3_full_a: assert property (
    I_TXN_VALID && mode_ff == 2'h0 && col_b3_sel <= 4'h7 |=>
      O_MAP_COL[4] == $past(I_TXN_ADDR[5'h03 + {1'b0, col_b3_sel}]))
    else $error("Full width column bit 4 wrong.");

  col_b3_quarter_a: assert property (
    I_TXN_VALID && mode_ff == 2'h2 && col_b3_sel <= 4'h7 |=>
      O_MAP_COL[6] == $past(I_TXN_ADDR[5'h03 + {1'b0, col_b3_sel}]))
    else $error("Quarter width column bit 6 wrong.");

  col_b4_full_a: assert property (
    I_TXN_VALID && mode_ff == 2'h0 && col_b4_sel <= 4'h7 |=>
      O_MAP_COL[5] == $past(I_TXN_ADDR[5'h04 + {1'b0, col_b4_sel}]))
    else $error("Full width column bit 5 wrong.");

  col_b4_half_a: assert property (
    I_TXN_VALID && mode_ff == 2'h1 && col_b4_sel <= 4'h7 |=>
      O_MAP_COL[6] == $past(I_TXN_ADDR[5'h04 + {1'b0, col_b4_sel}]))
    else $error("Half width column bit 6 wrong.");

  col_b7_full_a: assert property (
    I_TXN_VALID && mode_ff == 2'h0 && col_b7_sel <= 4'h7 |=>
      O_MAP_COL[8] == $past(I_TXN_ADDR[5'h07 + {1'b0, col_b7_sel}]) &&
      !O_MAP_COL[9] && !O_MAP_COL[11])
    else $error("Full width column bit 8 wrong.");

  col_b7_half_a: assert property (
    I_TXN_VALID && mode_ff == 2'h1 && col_b7_sel <= 4'h7 |=>
      O_MAP_COL[9] == $past(I_TXN_ADDR[5'h07 + {1'b0, col_b7_sel}]))
    else $error("Half width column bit 9 wrong.");

  map_hold_a: assert property (
    !I_TXN_VALID |=> $stable(O_MAP_BANK) && $stable(O_MAP_COL))
    else $error("Mapped bank or column changed without an address.");

  unsup_clear_a: assert property (
    unsup_clr && !unsup_set |=> !unsup_ff)
    else $error("Unsupported flag not cleared by software.");

  cov_full_map_c:    cover property (I_TXN_VALID && mode_ff == 2'b00 ##1 O_MAP_VALID);
  cov_quarter_map_c: cover property (I_TXN_VALID && mode_ff == 2'b10 ##1 O_MAP_VALID);
  cov_b7_off_c:      cover property (I_TXN_VALID && col_b7_sel == 4'hF);
  cov_set_clear_c:   cover property (unsup_set && unsup_clr);

endmodule : dbcam_top

`default_nettype wire

// ==== dbcam_pkg.sv ====
// Constants, register map and mode encoding for the bank and column address mapper.
`default_nettype none

package dbcam_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] OFS_BANK_SEL     = 8'h00;
  localparam logic [7:0] OFS_COL_LOW_SEL  = 8'h04;
  localparam logic [7:0] OFS_COL_HIGH_SEL = 8'h08;
  localparam logic [7:0] OFS_MODE         = 8'h0C;
  localparam logic [7:0] OFS_STATUS       = 8'h10;

  // Field positions inside the bank select register.
  localparam int BANK0_LSB = 8;
  localparam int BANK1_LSB = 4;
  localparam int BANK2_LSB = 0;

  // Field positions inside the low column select register.
  localparam int COL_B2_LSB = 12;
  localparam int COL_B3_LSB = 8;
  localparam int COL_B4_LSB = 4;
  localparam int COL_B7_LSB = 0;

  // Field position of the width mode and of the status fields.
  localparam int MODE_LSB        = 0;
  localparam int STAT_UNSUP_LSB  = 0;
  localparam int STAT_BANK_LSB   = 4;
  localparam int STAT_COL_LSB    = 8;

  // Internal bases added to each selector value.
  localparam logic [4:0] BANK0_BASE  = 5'h02;
  localparam logic [4:0] BANK1_BASE  = 5'h03;
  localparam logic [4:0] BANK2_BASE  = 5'h04;
  localparam logic [4:0] COL_B2_BASE = 5'h02;
  localparam logic [4:0] COL_B3_BASE = 5'h03;
  localparam logic [4:0] COL_B4_BASE = 5'h04;
  localparam logic [4:0] COL_B7_BASE = 5'h07;

  // Selector limits and the value that forces a mapped bit to zero.
  localparam logic [3:0] BANK_SEL_MAX = 4'hE;
  localparam logic [3:0] COL_SEL_MAX  = 4'h7;
  localparam logic [3:0] SEL_OFF      = 4'hF;

  // Values after reset.
  localparam logic [11:0] BANK_SEL_RST = 12'h000;
  localparam logic [15:0] COL_SEL_RST  = 16'h0000;
  localparam logic [1:0]  MODE_RST     = 2'h0;

  // Output widths.
  localparam int COL_W  = 12;
  localparam int BANK_W = 3;

  // Data bus width mode.
  typedef enum logic [1:0] {
    DBCAM_FULL    = 2'b00,
    DBCAM_HALF    = 2'b01,
    DBCAM_QUARTER = 2'b10,
    DBCAM_RSVD    = 2'b11
  } dbcam_width_t;

endpackage : dbcam_pkg

`default_nettype wire

// ==== dbcam_sched_model.sv ====
// Scheduler-side model that consumes each mapped bank and column.
`default_nettype none

module dbcam_sched_model (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Mapped address from the mapper.
  input  wire logic        i_map_valid,
  input  wire logic [2:0]  i_map_bank,
  input  wire logic [11:0] i_map_col,
  // Last mapping taken and how many arrived.
  output logic      [2:0]  o_bank,
  output logic      [11:0] o_col,
  output logic      [15:0] o_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  // The scheduler never stalls the mapper, so a valid cycle is taken at once.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bank <= 3'h0;
      o_col  <= 12'h000;
      o_cnt  <= 16'h0000;
    end else if (i_map_valid) begin
      o_bank <= i_map_bank;
      o_col  <= i_map_col;
      o_cnt  <= o_cnt + 16'h0001;
    end
  end
endmodule : dbcam_sched_model

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the bank and column address mapper.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Bench drive signals and counters, all given a value at time zero.
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  ra = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tv = 1'b0;
  logic [31:0] ta = 32'h0000_0000;
  logic [31:0] rdata;
  logic        mv;
  logic [2:0]  mb, gb;
  logic [11:0] mc, gc;
  logic [15:0] gn;
  int          err_total = 0;
  int          n_tests = 0;
  int          cb[4] = '{2, 3, 4, 7};
  int          cp[4][3] = '{'{3, 4, 5}, '{4, 5, 6}, '{5, 6, 7}, '{8, 9, 11}};

  always #20 clk = ~clk;

  dbcam_top dbcam_top_i (.I_CLK_SYS(clk), .I_RST(rst), .I_REG_ADDR(ra), .I_REG_WDATA(wd),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_TXN_VALID(tv), .I_TXN_ADDR(ta),
    .O_MAP_VALID(mv), .O_MAP_BANK(mb), .O_MAP_COL(mc));

  dbcam_sched_model dbcam_sched_model_i (.i_clk(clk), .i_rst(rst), .i_map_valid(mv),
    .i_map_bank(mb), .i_map_col(mc), .o_bank(gb), .o_col(gc), .o_cnt(gn));

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle register write.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    wd <= ~d;
  endtask : reg_wr

  // One-cycle register read; data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : reg_rd

  // Sends one address; the result must come exactly one cycle later, once.
  task automatic map_chk(input logic [31:0] a, input logic [2:0] eb, input logic [11:0] ec);
    logic [15:0] c0;
    c0 = gn;
    @(posedge clk);
    tv <= 1'b1;
    ta <= a;
    @(posedge clk);
    tv <= 1'b0;
    ta <= ~a;
    #1;
    chk("map valid", 32'h0000_0001, {31'h0, mv});
    @(posedge clk);
    #1;
    chk("bank", {29'h0, eb}, {29'h0, gb});
    chk("column", {20'h0, ec}, {20'h0, gc});
    chk("count", {16'h0, c0 + 16'h0001}, {16'h0, gn});
  endtask : map_chk

  // Bank bits walk every legal selector; column selectors are parked at fifteen.
  task automatic t_bank();
    reg_wr(dbcam_pkg::OFS_COL_LOW_SEL, 32'h0000_FFFF);
    for (int s = 0; s <= 14; s++) begin
      reg_wr(dbcam_pkg::OFS_BANK_SEL, s * 32'h0000_0111);
      map_chk(32'h0000_0001 << (2 + s), 3'h1, 12'h000);
      map_chk(32'h0000_0001 << (3 + s), 3'h2, 12'h000);
      map_chk(32'h0000_0001 << (4 + s), 3'h4, 12'h000);
    end
    reg_wr(dbcam_pkg::OFS_BANK_SEL, 32'h0000_000F);
    map_chk(32'hFFFF_FFFF, 3'h3, 12'h000);
    reg_wr(dbcam_pkg::OFS_BANK_SEL, 32'h0000_0FFF);
    map_chk(32'hFFFF_FFFF, 3'h0, 12'h000);
  endtask : t_bank

  // Column fields in every width mode, the zero code and the reserved mode.
  task automatic t_col();
    logic [11:0] e;
    // Bank bits sit on address bits 16 and 17 so they never overlap a column source.
    reg_wr(dbcam_pkg::OFS_BANK_SEL, 32'h0000_0EEF);
    reg_wr(dbcam_pkg::OFS_STATUS, 32'h0000_0001);
    reg_rd(dbcam_pkg::OFS_STATUS, 32'h0000_0000, "status before columns");
    for (int m = 0; m <= 2; m++) begin
      reg_wr(dbcam_pkg::OFS_MODE, m);
      for (int s = 0; s <= 7; s++) begin
        reg_wr(dbcam_pkg::OFS_COL_LOW_SEL, s * 32'h0000_1111);
        for (int k = 0; k < 4; k++) begin
          map_chk(32'h1 << (cb[k] + s), 3'h0, 12'h001 << cp[k][m]);
        end
      end
      reg_wr(dbcam_pkg::OFS_COL_LOW_SEL, 32'h0000_000F);
      e = (12'h001 << cp[0][m]) | (12'h001 << cp[1][m]) | (12'h001 << cp[2][m]);
      map_chk(32'hFFFF_FFFF, 3'h3, e);
    end
    reg_wr(dbcam_pkg::OFS_MODE, 32'h0000_0003);
    map_chk(32'hFFFF_FFFF, 3'h3, 12'h000);
    @(posedge clk);
    rd <= 1'b1;
    ra <= dbcam_pkg::OFS_STATUS;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("unsupported flag", 32'h0000_0001, rdata & 32'h0000_0001);
    reg_wr(dbcam_pkg::OFS_STATUS, 32'h0000_0001);
    reg_rd(dbcam_pkg::OFS_STATUS, 32'h0000_0030, "status cleared");
  endtask : t_col

  // Reserved bits read zero; software keeps them by read-modify-write.
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(dbcam_pkg::OFS_MODE, 32'h0000_0000, "mode at reset");
    reg_wr(dbcam_pkg::OFS_BANK_SEL, 32'hFFFF_F123);
    reg_rd(dbcam_pkg::OFS_BANK_SEL, 32'h0000_0123, "bank select");
    d = (32'h0000_0123 & ~32'h0000_00F0) | 32'h0000_0050;
    reg_wr(dbcam_pkg::OFS_BANK_SEL, d);
    reg_rd(dbcam_pkg::OFS_BANK_SEL, 32'h0000_0153, "bank after update");
    reg_wr(dbcam_pkg::OFS_COL_HIGH_SEL, 32'hFFFF_ABCD);
    reg_rd(dbcam_pkg::OFS_COL_HIGH_SEL, 32'h0000_ABCD, "column high select");
    reg_wr(8'h14, 32'hFFFF_FFFF);
    reg_rd(8'h14, 32'h0000_0000, "unmapped offset");
  endtask : t_regs

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // Main sequence, ending with a mid-run reset that must restore the defaults.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bank();
    t_col();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(dbcam_pkg::OFS_BANK_SEL, 32'h0000_0000, "bank after reset");
    reg_rd(dbcam_pkg::OFS_MODE, 32'h0000_0000, "mode after reset");
    chk("bank out after reset", 32'h0000_0000, {29'h0, mb});
    chk("column out after reset", 32'h0000_0000, {20'h0, mc});
    summarize();
  end

  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : tb

`default_nettype wire
